// ===== shared/selector_regs.vh
// Register offsets, field positions, reset values and timing counts of the selector element
`ifndef SELECTOR_REGS_VH
`define SELECTOR_REGS_VH

// Clock rate and derived timing
`define CLK_HZ 100000000
`define ALARM_HOLD_S 3
`define ALARM_HOLD_CYC (`ALARM_HOLD_S * `CLK_HZ)
`define TIMEOUT_DEF_MS 5000
`define TIMEOUT_DEF_CYC (`TIMEOUT_DEF_MS * (`CLK_HZ / 1000))

// Register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_TIMEOUT 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_INT_STATUS 8'h0C
`define ADDR_INT_MASK 8'h10
`define ADDR_LAST_EVENT 8'h14

// Control register fields
`define CTRL_RANGE_LSB 0
`define CTRL_STEP_ACK_BIT 3
`define CTRL_WORD_ACK_BIT 4
`define CTRL_EVENTS_BIT 5
`define CTRL_RANGE_RST 3'h7

// Status register fields
`define STAT_POS_LSB 0
`define STAT_PRE_LSB 4
`define STAT_STEP_BUSY_BIT 8
`define STAT_WORD_BUSY_BIT 9
`define STAT_PWR_ALM_BIT 12
`define STAT_STEP_ALM_BIT 13
`define STAT_WORD_ALM_BIT 14

// Interrupt status and mask bits
`define INT_POS_BIT 0
`define INT_STEP_BIT 1
`define INT_WORD_BIT 2
`define INT_PWR_BIT 3

// Event record codes
`define EV_NONE 2'h0
`define EV_POS 2'h1
`define EV_STEP_ALM 2'h2
`define EV_WORD_ALM 2'h3

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== rtl/alarm_stretch.v
// Holds an alarm level for a fixed number of cycles after each trigger
`timescale 1ns/1ps
`default_nettype none

module alarm_stretch #(
  parameter [31:0] HOLD_CYCLES = 32'h0000_0010
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Trigger pulse and held level
  input wire trigger,
  output wire active
);

  reg [31:0] cnt_q; // Cycles left in the hold
  reg active_q; // Held alarm level

  // Retrigger restarts the full hold; level lasts exactly HOLD_CYCLES
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 32'h0000_0000;
      active_q <= 1'b0;
    end else if (trigger) begin
      cnt_q <= HOLD_CYCLES;
      active_q <= 1'b1;
    end else begin
      if (cnt_q != 32'h0000_0000) begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end
      active_q <= (cnt_q > 32'h0000_0001);
    end
  end

  assign active = active_q;

endmodule // alarm_stretch

`default_nettype wire

// ===== rtl/selector_switch.v
// Selector element: power-up, step and word selection, alarms, events, AXI4-Lite registers
// Function
// - Restore policy reloads stored position
// - Sync policy takes current select word
// - Sync applies immediately, no timeout, confirm
// - Rest or out-of-range word: position 0, alarm
// - Out-of-range stored position: position 0, alarm
// - Log event with new position on change
// - Log alarm for unconfirmed step preselection
// - Log alarm for unconfirmed word preselection
// - Show position one-hot and as code
// - Word values 1-7 map, 000 rests
// - Each alarm held three seconds
// - Step edge increments, wraps to 1
// - Step and word paths lock out mutually
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "selector_regs.vh"

module selector_switch #(
  parameter [31:0] ALARM_HOLD_CYCLES = `ALARM_HOLD_CYC
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [7:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // AXI4-Lite write response
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // AXI4-Lite read
  input wire [7:0] araddr,
  input wire arvalid,
  output wire arready,
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready,
  // Control inputs
  input wire step_advance_input,
  input wire step_confirm_input,
  input wire [2:0] select_word_input,
  input wire word_confirm_input,
  input wire powerup_policy,
  // Non-volatile position storage
  input wire [2:0] nv_pos_in,
  output wire nv_write,
  output wire [2:0] nv_pos_out,
  // Position outputs
  output wire [7:1] pos_flags,
  output wire [2:0] pos_code,
  // Alarms
  output wire powerup_fault_flag,
  output wire step_confirm_fault_flag,
  output wire word_confirm_fault_flag,
  output wire any_fault_flag,
  // Event record
  output wire event_valid,
  output wire [1:0] event_code,
  output wire [2:0] event_pos,
  // Interrupt
  output wire irq
);

  // Sequencer states
  localparam [1:0] ST_INIT = 2'h0;
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_STEP = 2'h2;
  localparam [1:0] ST_WORD = 2'h3;

  // Word is a real position within the configured range
  function in_range;
    input [2:0] p;
    input [2:0] full;
    begin
      in_range = (p != 3'h0) && (p <= full);
    end
  endfunction

  // Next step position with wrap to position 1
  function [2:0] next_step;
    input [2:0] p;
    input [2:0] full;
    begin
      next_step = (p >= full) ? 3'h1 : p + 3'h1;
    end
  endfunction

  // Byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Configuration registers
  reg [2:0] range_q; // Upper position limit
  reg step_ack_q; // Step path needs confirm
  reg word_ack_q; // Word path needs confirm
  reg events_q; // Event logging enable
  reg [31:0] timeout_q; // Commit timeout in cycles
  reg [3:0] int_status_q; // Sticky event bits
  reg [3:0] int_mask_q; // Interrupt enables
  reg irq_q; // Interrupt output
  // Sequencer state
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [2:0] pos_q; // Active position, 0 means none
  reg [2:0] pre_q; // Preselected position
  reg [2:0] pre_d;
  reg [31:0] tmr_q; // Commit timer
  reg [31:0] tmr_d;
  reg step_prev_q; // Edge detection history
  reg sconf_prev_q;
  reg wconf_prev_q;
  reg [2:0] word_prev_q;
  // Outputs from flops
  reg [7:1] flags_q;
  reg nv_write_q;
  reg ev_valid_q;
  reg [1:0] ev_code_q;
  reg [2:0] ev_pos_q;
  reg [5:0] last_event_q;
  reg any_q;
  // Apply and alarm strobes
  reg do_apply;
  reg [2:0] apply_pos;
  reg pwr_set;
  reg step_set;
  reg word_set;
  // Bus slave state
  reg awready_q;
  reg wready_q;
  reg aw_got_q;
  reg w_got_q;
  reg [7:0] waddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;

  wire pwr_alm;
  wire step_alm;
  wire word_alm;
  wire step_rise = step_advance_input & ~step_prev_q;
  wire sconf_rise = step_confirm_input & ~sconf_prev_q;
  wire wconf_rise = word_confirm_input & ~wconf_prev_q;
  wire word_chg = (select_word_input != word_prev_q);
  // A zero timeout would never expire; treat it as one cycle
  wire [31:0] tout = (timeout_q == 32'h0000_0000) ? 32'h0000_0001 : timeout_q;
  wire pos_changed = do_apply && (apply_pos != pos_q);
  wire wr_en = aw_got_q && w_got_q && !bvalid_q;
  wire [3:0] int_events = {pwr_set, word_set, step_set, pos_changed};

  // Selection sequencer decision
  always @* begin
    st_d = st_q;
    pre_d = pre_q;
    tmr_d = (tmr_q != 32'h0000_0000) ? tmr_q - 32'h0000_0001 : tmr_q;
    do_apply = 1'b0;
    apply_pos = pre_q;
    pwr_set = 1'b0;
    step_set = 1'b0;
    word_set = 1'b0;
    case (st_q)
      ST_INIT: begin
        st_d = ST_IDLE;
        do_apply = 1'b1;
        if (powerup_policy) begin
          if (in_range(select_word_input, range_q)) begin
            apply_pos = select_word_input;
          end else begin
            apply_pos = 3'h0;
            pwr_set = 1'b1;
          end
        end else begin
          if (nv_pos_in <= range_q) begin
            apply_pos = nv_pos_in;
          end else begin
            apply_pos = 3'h0;
            pwr_set = 1'b1;
          end
        end
      end
      ST_IDLE: begin
        // Step wins a same-cycle tie with a word change
        if (step_rise) begin
          st_d = ST_STEP;
          pre_d = next_step(pos_q, range_q);
          tmr_d = tout;
        end else if (word_chg && select_word_input != 3'h0) begin
          if (in_range(select_word_input, range_q)) begin
            st_d = ST_WORD;
            pre_d = select_word_input;
            tmr_d = tout;
          end else begin
            word_set = 1'b1;
          end
        end
      end
      ST_STEP: begin
        if (step_rise) begin
          pre_d = next_step(pre_q, range_q);
          tmr_d = tout;
        end else if (step_ack_q && sconf_rise) begin
          st_d = ST_IDLE;
          do_apply = 1'b1;
        end else if (tmr_q == 32'h0000_0001) begin
          st_d = ST_IDLE;
          step_set = step_ack_q;
          do_apply = !step_ack_q;
        end
      end
      ST_WORD: begin
        if (word_chg && select_word_input != 3'h0) begin
          if (in_range(select_word_input, range_q)) begin
            pre_d = select_word_input;
            tmr_d = tout;
          end else begin
            // Out-of-range word aborts the sequence
            st_d = ST_IDLE;
            word_set = 1'b1;
          end
        end else if (word_ack_q && wconf_rise) begin
          st_d = ST_IDLE;
          do_apply = 1'b1;
        end else if (tmr_q == 32'h0000_0001) begin
          st_d = ST_IDLE;
          word_set = word_ack_q;
          do_apply = !word_ack_q;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // Sequencer, position outputs, storage and event record
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_INIT;
      pos_q <= 3'h0;
      pre_q <= 3'h0;
      tmr_q <= 32'h0000_0000;
      step_prev_q <= 1'b0;
      sconf_prev_q <= 1'b0;
      wconf_prev_q <= 1'b0;
      word_prev_q <= 3'h0;
      flags_q <= 7'h00;
      nv_write_q <= 1'b0;
      ev_valid_q <= 1'b0;
      ev_code_q <= `EV_NONE;
      ev_pos_q <= 3'h0;
      last_event_q <= 6'h00;
      any_q <= 1'b0;
    end else begin
      st_q <= st_d;
      pre_q <= pre_d;
      tmr_q <= tmr_d;
      step_prev_q <= step_advance_input;
      sconf_prev_q <= step_confirm_input;
      wconf_prev_q <= word_confirm_input;
      word_prev_q <= select_word_input;
      any_q <= pwr_alm | step_alm | word_alm;
      nv_write_q <= do_apply;
      if (do_apply) begin
        pos_q <= apply_pos;
        flags_q <= (apply_pos == 3'h0) ? 7'h00 : (7'h01 << (apply_pos - 3'h1));
      end
      ev_valid_q <= 1'b0;
      // Only one event can occur per cycle by construction
      if (events_q) begin
        if (pos_changed) begin
          ev_valid_q <= 1'b1;
          ev_code_q <= `EV_POS;
          ev_pos_q <= apply_pos;
          last_event_q <= {1'b0, `EV_POS, apply_pos};
        end else if (step_set) begin
          ev_valid_q <= 1'b1;
          ev_code_q <= `EV_STEP_ALM;
          ev_pos_q <= pre_q;
          last_event_q <= {1'b0, `EV_STEP_ALM, pre_q};
        end else if (word_set) begin
          ev_valid_q <= 1'b1;
          ev_code_q <= `EV_WORD_ALM;
          ev_pos_q <= select_word_input;
          last_event_q <= {1'b0, `EV_WORD_ALM, select_word_input};
        end
      end
    end
  end

  alarm_stretch #(.HOLD_CYCLES(ALARM_HOLD_CYCLES)) u_pwr (
    .aclk(aclk), .aresetn(aresetn), .trigger(pwr_set), .active(pwr_alm));
  alarm_stretch #(.HOLD_CYCLES(ALARM_HOLD_CYCLES)) u_step (
    .aclk(aclk), .aresetn(aresetn), .trigger(step_set), .active(step_alm));
  alarm_stretch #(.HOLD_CYCLES(ALARM_HOLD_CYCLES)) u_word (
    .aclk(aclk), .aresetn(aresetn), .trigger(word_set), .active(word_alm));

  // Bus write path, config registers and sticky interrupt bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
      range_q <= `CTRL_RANGE_RST;
      step_ack_q <= 1'b0;
      word_ack_q <= 1'b0;
      events_q <= 1'b0;
      timeout_q <= `TIMEOUT_DEF_CYC;
      int_status_q <= 4'h0;
      int_mask_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      // Ready is a one-cycle pulse once valid is seen; master holds valid meanwhile
      awready_q <= awvalid && !awready_q && !aw_got_q && !bvalid_q;
      wready_q <= wvalid && !wready_q && !w_got_q && !bvalid_q;
      if (awvalid && awready_q) begin
        aw_got_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_got_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
      // Hardware set wins over a write-one-to-clear in the same cycle
      int_status_q <= int_status_q | int_events;
      if (wr_en) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= `RESP_OKAY;
        case ({waddr_q[7:2], 2'b00})
          `ADDR_CTRL: begin
            if (wstrb_q[0]) begin
              range_q <= wdata_q[`CTRL_RANGE_LSB +: 3];
              step_ack_q <= wdata_q[`CTRL_STEP_ACK_BIT];
              word_ack_q <= wdata_q[`CTRL_WORD_ACK_BIT];
              events_q <= wdata_q[`CTRL_EVENTS_BIT];
            end
          end
          `ADDR_TIMEOUT: timeout_q <= merge(timeout_q, wdata_q, wstrb_q);
          `ADDR_INT_STATUS: begin
            if (wstrb_q[0]) begin
              int_status_q <= (int_status_q & ~wdata_q[3:0]) | int_events;
            end
          end
          `ADDR_INT_MASK: begin
            if (wstrb_q[0]) begin
              int_mask_q <= wdata_q[3:0];
            end
          end
          `ADDR_STATUS, `ADDR_LAST_EVENT: bresp_q <= `RESP_OKAY;
          default: bresp_q <= `RESP_SLVERR;
        endcase
      end
      // Level interrupt, one cycle behind the sticky bits
      irq_q <= |(int_status_q & int_mask_q);
    end
  end

  // Bus read path; reads have no side effects
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else begin
      arready_q <= arvalid && !arready_q && !rvalid_q;
      if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
      if (arvalid && arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q <= `RESP_OKAY;
        rdata_q <= 32'h0000_0000;
        case ({araddr[7:2], 2'b00})
          `ADDR_CTRL: begin
            rdata_q[`CTRL_RANGE_LSB +: 3] <= range_q;
            rdata_q[`CTRL_STEP_ACK_BIT] <= step_ack_q;
            rdata_q[`CTRL_WORD_ACK_BIT] <= word_ack_q;
            rdata_q[`CTRL_EVENTS_BIT] <= events_q;
          end
          `ADDR_TIMEOUT: rdata_q <= timeout_q;
          `ADDR_STATUS: begin
            rdata_q[`STAT_POS_LSB +: 3] <= pos_q;
            rdata_q[`STAT_PRE_LSB +: 3] <= pre_q;
            rdata_q[`STAT_STEP_BUSY_BIT] <= (st_q == ST_STEP);
            rdata_q[`STAT_WORD_BUSY_BIT] <= (st_q == ST_WORD);
            rdata_q[`STAT_PWR_ALM_BIT] <= pwr_alm;
            rdata_q[`STAT_STEP_ALM_BIT] <= step_alm;
            rdata_q[`STAT_WORD_ALM_BIT] <= word_alm;
          end
          `ADDR_INT_STATUS: rdata_q[3:0] <= int_status_q;
          `ADDR_INT_MASK: rdata_q[3:0] <= int_mask_q;
          `ADDR_LAST_EVENT: rdata_q[5:0] <= last_event_q;
          default: rresp_q <= `RESP_SLVERR;
        endcase
      end
    end
  end

  // Output wiring, all straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign nv_write = nv_write_q;
  assign nv_pos_out = pos_q;
  assign pos_flags = flags_q;
  assign pos_code = pos_q;
  assign powerup_fault_flag = pwr_alm;
  assign step_confirm_fault_flag = step_alm;
  assign word_confirm_fault_flag = word_alm;
  assign any_fault_flag = any_q;
  assign event_valid = ev_valid_q;
  assign event_code = ev_code_q;
  assign event_pos = ev_pos_q;
  assign irq = irq_q;

endmodule // selector_switch

`default_nettype wire

// ===== sim/nv_store_model.sv
// Non-volatile position store seen from the selector element
`timescale 1ns/1ps
`default_nettype none

module nv_store_model (
  // Clock
  input wire logic aclk,
  // Bench preload
  input wire logic load,
  input wire logic [2:0] seed,
  // Element side
  input wire logic nv_write,
  input wire logic [2:0] nv_pos_out,
  output var logic [2:0] nv_pos_in
);
  // Stored word survives reset; only a preload or a write changes it
  always @(posedge aclk) begin
    if (load) begin
      nv_pos_in <= seed;
    end else if (nv_write) begin
      nv_pos_in <= nv_pos_out;
    end
  end
endmodule // nv_store_model

`default_nettype wire

// ===== sim/selector_switch_properties.sv
// Concurrent checks on the selector element's ports
`timescale 1ns/1ps
`default_nettype none
`include "selector_regs.vh"

module selector_switch_props #(
  parameter [31:0] ALARM_HOLD_CYCLES = 32'h0000_0010
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selector inputs
  input wire logic [2:0] select_word_input,
  input wire logic powerup_policy,
  input wire logic [2:0] nv_pos_in,
  // Selector outputs
  input wire logic nv_write,
  input wire logic [2:0] nv_pos_out,
  input wire logic [7:1] pos_flags,
  input wire logic [2:0] pos_code,
  input wire logic powerup_fault_flag,
  input wire logic step_confirm_fault_flag,
  input wire logic word_confirm_fault_flag,
  input wire logic any_fault_flag,
  input wire logic event_valid,
  input wire logic [1:0] event_code,
  input wire logic [2:0] event_pos
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // High-time counter of the power-up alarm; power-up never retriggers it
  logic [31:0] hold_q;
  always @(posedge aclk) begin
    if (!aresetn || !powerup_fault_flag) begin
      hold_q <= 32'h0;
    end else begin
      hold_q <= hold_q + 32'h1;
    end
  end

  property p_onehot;
    pos_flags == 7'((8'h01 << pos_code) >> 1);
  endproperty
  a_onehot: assert property (p_onehot) else $error("flags disagree with code");
  property p_any;
    any_fault_flag == $past(powerup_fault_flag || step_confirm_fault_flag || word_confirm_fault_flag);
  endproperty
  a_any: assert property (p_any) else $error("combined alarm wrong");
  property p_nvpos;
    nv_write |-> nv_pos_out == pos_code ##1 !nv_write;
  endproperty
  a_nvpos: assert property (p_nvpos) else $error("stored value not position");
  property p_changed;
    $changed(pos_code) |-> nv_write;
  endproperty
  a_changed: assert property (p_changed) else $error("position change not stored");
  property p_evpos;
    event_valid && event_code == `EV_POS |-> event_pos == pos_code;
  endproperty
  a_evpos: assert property (p_evpos) else $error("position event wrong");
  property p_hold;
    $fell(powerup_fault_flag) |-> hold_q == ALARM_HOLD_CYCLES;
  endproperty
  a_hold: assert property (p_hold) else $error("alarm hold length wrong");
  property p_restore;
    $rose(aresetn) && !powerup_policy |=> pos_code == $past(nv_pos_in) && !powerup_fault_flag;
  endproperty
  a_restore: assert property (p_restore) else $error("restore failed");
  property p_sync;
    $rose(aresetn) && powerup_policy && select_word_input != 3'h0
      |=> pos_code == $past(select_word_input);
  endproperty
  a_sync: assert property (p_sync) else $error("sync not immediate");
  property p_rest;
    $rose(aresetn) && powerup_policy && select_word_input == 3'h0
      |=> pos_code == 3'h0 && powerup_fault_flag;
  endproperty
  a_rest: assert property (p_rest) else $error("rest word not faulted");
endmodule // selector_switch_props

bind selector_switch selector_switch_props #(.ALARM_HOLD_CYCLES(ALARM_HOLD_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .select_word_input(select_word_input),
  .powerup_policy(powerup_policy), .nv_pos_in(nv_pos_in), .nv_write(nv_write),
  .nv_pos_out(nv_pos_out), .pos_flags(pos_flags), .pos_code(pos_code),
  .powerup_fault_flag(powerup_fault_flag), .step_confirm_fault_flag(step_confirm_fault_flag),
  .word_confirm_fault_flag(word_confirm_fault_flag), .any_fault_flag(any_fault_flag),
  .event_valid(event_valid), .event_code(event_code), .event_pos(event_pos)
);

`default_nettype wire

// ===== sim/tb_selector_switch.sv
// Self-checking bench for the selector element
`timescale 1ns/1ps
`default_nettype none
`include "selector_regs.vh"

module tb_selector_switch;
  localparam int HOLD = 20; // Short alarm hold keeps the run brief
  // Bus signals
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, nv_write, irq, ev_v;
  logic [1:0] bresp, rresp, ev_c, rsp;
  // Selector signals
  logic step = 1'h0, s_ack = 1'h0, w_ack = 1'h0, pol = 1'h0, load = 1'h1;
  logic [2:0] word = 3'h0, seed = 3'h0, nv_in, nv_out, pos, ev_p;
  logic [7:1] flags;
  logic p_alm, s_alm, w_alm, a_alm;
  int n_fail = 0, checks_done = 0;
  // Power-up cases: policy, stored, word, expected position and alarm
  typedef struct packed {logic p; logic [2:0] nv; logic [2:0] w; logic [2:0] pos; logic a;} row_t;
  row_t rows [6] = '{'{1'h0, 3'h3, 3'h6, 3'h3, 1'h0}, '{1'h0, 3'h0, 3'h5, 3'h0, 1'h0},
    '{1'h1, 3'h4, 3'h5, 3'h5, 1'h0}, '{1'h1, 3'h1, 3'h7, 3'h7, 1'h0},
    '{1'h1, 3'h2, 3'h0, 3'h0, 1'h1}, '{1'h1, 3'h6, 3'h2, 3'h2, 1'h0}};

  selector_switch #(.ALARM_HOLD_CYCLES(HOLD)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .step_advance_input(step), .step_confirm_input(s_ack), .select_word_input(word),
    .word_confirm_input(w_ack), .powerup_policy(pol), .nv_pos_in(nv_in), .nv_write(nv_write),
    .nv_pos_out(nv_out), .pos_flags(flags), .pos_code(pos), .powerup_fault_flag(p_alm),
    .step_confirm_fault_flag(s_alm), .word_confirm_fault_flag(w_alm), .any_fault_flag(a_alm),
    .event_valid(ev_v), .event_code(ev_c), .event_pos(ev_p), .irq(irq)
  );
  nv_store_model nvm (
    .aclk(aclk), .load(load), .seed(seed), .nv_write(nv_write), .nv_pos_out(nv_out),
    .nv_pos_in(nv_in)
  );

  initial begin
    forever #5 aclk = ~aclk;
  end

  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  // Eight-cycle reset, then the power-up edge
  task automatic power_up(input logic p, input logic [2:0] nv, input logic [2:0] w, input logic ld);
    @(posedge aclk);
    aresetn <= 1'h0;
    pol <= p;
    seed <= nv;
    load <= ld;
    word <= w;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    load <= 1'h0;
    @(posedge aclk);
    #1;
  endtask
  task automatic wait_ev(input logic [1:0] c, input logic [2:0] p);
    do @(posedge aclk); while (ev_v !== 1'h1);
    chk("event_code", c, ev_c);
    chk("event_pos", p, ev_p);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    foreach (rows[i]) begin
      power_up(rows[i].p, rows[i].nv, rows[i].w, 1'h1);
      chk("pos_code", rows[i].pos, pos);
      chk("pos_flags", (8'h01 << rows[i].pos) >> 1, flags);
      chk("nv_write", 1, nv_write);
      chk("pwr_alarm", rows[i].a, p_alm);
      if (rows[i].a) begin
        repeat (HOLD - 1) @(posedge aclk);
        #1;
        chk("alarm_held", 1, p_alm);
        chk("any_alarm", 1, a_alm);
        @(posedge aclk);
        #1;
        chk("alarm_end", 0, p_alm);
      end
    end
    axi_rd(`ADDR_CTRL);
    chk("ctrl_reset", 32'h7, rd);
    axi_rd(`ADDR_TIMEOUT);
    chk("timeout_reset", 32'h1DCD_6500, rd);
    axi_rd(8'h40);
    chk("unmapped_rd", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    axi_wr(8'h44, 32'h1);
    chk("unmapped_wr", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    axi_wr(`ADDR_TIMEOUT, 32'hA);
    // Clear power-up leftovers so the interrupt check below needs the step event
    axi_wr(`ADDR_INT_STATUS, 32'hF);
    axi_wr(`ADDR_INT_MASK, 32'h1);
    axi_wr(`ADDR_CTRL, 32'h23);
    // Step from 2 while the word moves: word path locked out
    step <= 1'h1;
    @(posedge aclk) step <= 1'h0;
    @(posedge aclk) word <= 3'h1;
    wait_ev(`EV_POS, 3'h3);
    @(posedge aclk);
    #1;
    chk("irq_on", 1, irq);
    axi_rd(`ADDR_INT_STATUS);
    chk("int_status", 32'h1, rd);
    axi_wr(`ADDR_INT_STATUS, 32'h1);
    axi_wr(`ADDR_INT_MASK, 32'h0);
    axi_rd(`ADDR_INT_STATUS);
    chk("int_cleared", 32'h0, rd);
    // Wrap past range 3, masked interrupt
    step <= 1'h1;
    @(posedge aclk) step <= 1'h0;
    wait_ev(`EV_POS, 3'h1);
    chk("irq_masked", 0, irq);
    // Word path with confirm required: timeout first, then confirmed
    axi_wr(`ADDR_CTRL, 32'h33);
    word <= 3'h2;
    wait_ev(`EV_WORD_ALM, 3'h2);
    chk("word_alarm", 1, w_alm);
    @(posedge aclk) word <= 3'h3;
    repeat (2) @(posedge aclk);
    w_ack <= 1'h1;
    @(posedge aclk) w_ack <= 1'h0;
    wait_ev(`EV_POS, 3'h3);
    // Step path with confirm required
    axi_wr(`ADDR_CTRL, 32'h2B);
    step <= 1'h1;
    @(posedge aclk) step <= 1'h0;
    wait_ev(`EV_STEP_ALM, 3'h1);
    @(posedge aclk);
    #1;
    chk("step_alarm", 1, s_alm);
    chk("any_alarm", 1, a_alm);
    @(posedge aclk);
    step <= 1'h1;
    @(posedge aclk) step <= 1'h0;
    repeat (2) @(posedge aclk);
    s_ack <= 1'h1;
    @(posedge aclk) s_ack <= 1'h0;
    wait_ev(`EV_POS, 3'h1);
    axi_rd(`ADDR_STATUS);
    chk("status_pos", 32'h1, {29'h0, rd[2:0]});
    // Word beyond range 3 raises the word alarm at once
    word <= 3'h5;
    wait_ev(`EV_WORD_ALM, 3'h5);
    // Restore recovers the last applied position
    power_up(1'h0, 3'h0, 3'h0, 1'h0);
    chk("restored", 3'h1, pos);
    tally_and_finish();
  end
endmodule // tb_selector_switch

`default_nettype wire
